// ===== common/dflash_seq_pkg.sv
// Constants shared by the data-flash command sequencer and its checker.
package dflash_seq_pkg;

  // ********************************************************************
  // Register byte offsets on the AHB-Lite bus
  // ********************************************************************
  localparam logic [7:0] OFF_FLASH_STATUS  = 8'h00;
  localparam logic [7:0] OFF_FLASH_CONFIG  = 8'h04;
  localparam logic [7:0] OFF_ERROR_STATUS  = 8'h08;
  localparam logic [7:0] OFF_ERROR_CONFIG  = 8'h0C;
  localparam logic [7:0] OFF_PARAM_INDEX   = 8'h10;
  localparam logic [7:0] OFF_COMMAND_PARAM = 8'h14;
  localparam logic [7:0] OFF_PROTECTION    = 8'h18;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int BIT_CCF      = 7;   // command_complete_flag
  localparam int BIT_ACCESS_ERROR_FLAG   = 5;   // access_error_flag
  localparam int BIT_PVIOL    = 4;   // protection_violation_flag
  localparam int BIT_VERR     = 1;   // verify_error_flag
  localparam int BIT_VFATAL   = 0;   // verify_fatal_flag
  localparam int BIT_COMMAND_COMPLETE_IRQ_EN     = 7;   // command_complete_irq_en
  localparam int BIT_DOUBLE   = 1;   // double fault flag and enable
  localparam int BIT_SINGLE   = 0;   // single fault flag and enable
  localparam int BIT_PROT_EN  = 16;  // protection enable

  // ********************************************************************
  // Command codes, index values and reset values
  // ********************************************************************
  localparam logic [7:0]  CMD_PROGRAM_WORD = 8'h11;
  localparam logic [7:0]  CMD_ERASE_SECTOR = 8'h12;
  localparam logic [2:0]  IDX_ERASE        = 3'h1;
  localparam logic [2:0]  IDX_PROG_MIN     = 3'h2;
  localparam logic [2:0]  IDX_PROG_MAX     = 3'h5;
  localparam int          NUM_SLOTS        = 6;
  localparam logic [2:0]  PARAM_INDEX_RST  = 3'h0;
  localparam logic [16:0] PROTECTION_RST   = 17'h00000;

  // ********************************************************************
  // Data-flash geometry defaults
  // ********************************************************************
  localparam logic [6:0]  DF_BLOCK_ID_DEF  = 7'h10;
  localparam logic [16:0] DF_SIZE_DEF      = 17'h08000;
  localparam logic [16:0] DF_SECTOR_DEF    = 17'h00100;

  // Sequencer states.
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ISSUE,
    SEQ_WAIT
  } seq_state_t;

endpackage

// ===== rtl/dflash_cmd_check.sv
// Launch-time legality check of a data-flash command.
`timescale 1ns/1ns
`default_nettype none
module dflash_cmd_check
  import dflash_seq_pkg::*;
#(
  parameter logic [6:0]  BLOCK_ID    = DF_BLOCK_ID_DEF,
  parameter logic [16:0] DF_SIZE     = DF_SIZE_DEF,
  parameter logic [16:0] SECTOR_SIZE = DF_SECTOR_DEF
) (
  input  wire logic [15:0] slot0,
  input  wire logic [15:0] slot1,
  input  wire logic [2:0]  index,
  input  wire logic        mode_ok,
  input  wire logic        prot_en,
  input  wire logic [15:0] prot_start,
  output logic             access_err,
  output logic             prot_err,
  output logic             is_erase,
  output logic [2:0]       word_count,
  output logic [15:0]      first_addr
);

  logic        is_prog;
  logic [16:0] run_end;
  logic [16:0] sect_base;
  logic [16:0] last_addr;

  // Decode the command and work out the span of bytes it touches.
  always_comb begin
    is_prog    = (slot0[15:8] == CMD_PROGRAM_WORD);
    is_erase   = (slot0[15:8] == CMD_ERASE_SECTOR);
    word_count = is_prog ? (index - 3'h1) : 3'h1;
    sect_base  = {1'b0, slot1} & ~(SECTOR_SIZE - 17'h00001);
    run_end    = {1'b0, slot1} + {13'h0000, word_count, 1'b0};
    last_addr  = is_erase ? (sect_base + SECTOR_SIZE - 17'h00001)
                          : (run_end - 17'h00001);
    first_addr = is_erase ? sect_base[15:0] : slot1;
  end

  // Any failed check refuses the launch; the address must sit in the block.
  always_comb begin
    access_err = 1'b0;
    if (!is_prog && !is_erase) begin
      access_err = 1'b1;
    end
    if (is_prog && (index < IDX_PROG_MIN || index > IDX_PROG_MAX)) begin
      access_err = 1'b1;
    end
    if (is_erase && index != IDX_ERASE) begin
      access_err = 1'b1;
    end
    if (!mode_ok) begin
      access_err = 1'b1;
    end
    if (slot0[6:0] != BLOCK_ID || {1'b0, slot1} >= DF_SIZE) begin
      access_err = 1'b1;
    end
    if (slot1[0]) begin
      access_err = 1'b1;
    end
    if (is_prog && run_end > DF_SIZE) begin
      access_err = 1'b1;
    end
  end

  // The run is protected when its top reaches into the guarded region.
  assign prot_err = prot_en && (last_addr >= {1'b0, prot_start});

endmodule
`default_nettype wire

// ===== rtl/dflash_cmd_sequencer.sv
// Data-flash command sequencer with AHB-Lite registers and array port.
//
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module dflash_cmd_sequencer
  import dflash_seq_pkg::*;
#(
  parameter logic [6:0]  BLOCK_ID    = DF_BLOCK_ID_DEF,
  parameter logic [16:0] DF_SIZE     = DF_SIZE_DEF,
  parameter logic [16:0] SECTOR_SIZE = DF_SECTOR_DEF
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        mode_allows_cmd,
  input  wire logic        ecc_single_fault,
  input  wire logic        ecc_double_fault,
  output logic             array_req,
  output logic             array_erase,
  output logic [15:0]      array_addr,
  output logic [15:0]      array_wdata,
  input  wire logic        array_done,
  input  wire logic        array_verify_err,
  input  wire logic        array_verify_fatal,
  output logic             irq_cmd_complete,
  output logic             irq_double_fault,
  output logic             irq_single_fault
);

  // ********************************************************************
  // Register state
  // ********************************************************************
  logic              command_complete_flag;
  logic              access_error_flag;
  logic              protection_violation_flag;
  logic              verify_error_flag;
  logic              verify_fatal_flag;
  logic              command_complete_irq_en;
  logic              double_fault_flag;
  logic              single_fault_flag;
  logic              double_fault_irq_en;
  logic              single_fault_irq_en;
  logic [2:0]        param_index;
  logic [16:0]       protection;
  logic [15:0]       command_param_reg [0:NUM_SLOTS-1];

  // ********************************************************************
  // Bus and sequencer signals
  // ********************************************************************
  logic              dp_write;
  logic [7:0]        dp_offset;
  logic              ap_valid;
  logic              launch_try;
  logic              launch_go;
  logic              seq_done;
  logic              chk_access_err;
  logic              chk_prot_err;
  logic              chk_is_erase;
  logic [2:0]        chk_word_count;
  logic [15:0]       chk_first_addr;
  logic [31:0]       next_hrdata;
  seq_state_t        seq_state;
  logic [2:0]        words_left;
  logic [2:0]        slot_ptr;
  logic              cur_erase;
  logic [15:0]       cur_addr;

  // True when a data-phase write targets the given register.
  function automatic logic wr_hit(input logic       wr,
                                  input logic [7:0] off,
                                  input logic [7:0] reg_off);
    wr_hit = wr && (off == reg_off);
  endfunction

  // ********************************************************************
  // AHB-Lite slave front end
  // ********************************************************************

  // Every access completes with no wait state and an OKAY answer.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ap_valid  = hsel && htrans[1] && hready;

  // Hold the address phase so the write lands in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write  <= 1'b0;
      dp_offset <= 8'h00;
    end else begin
      dp_write  <= ap_valid && hwrite;
      dp_offset <= haddr[7:0];
    end
  end

  // Read data is chosen in the address phase and registered for the data
  // phase. The master idles between transfers, so a preceding write has
  // always settled before the next read samples the registers.
  always_comb begin
    next_hrdata = 32'h00000000;
    case (haddr[7:0])
      OFF_FLASH_STATUS: begin
        next_hrdata[BIT_CCF]    = command_complete_flag;
        next_hrdata[BIT_ACCESS_ERROR_FLAG] = access_error_flag;
        next_hrdata[BIT_PVIOL]  = protection_violation_flag;
        next_hrdata[BIT_VERR]   = verify_error_flag;
        next_hrdata[BIT_VFATAL] = verify_fatal_flag;
      end
      OFF_FLASH_CONFIG: begin
        next_hrdata[BIT_COMMAND_COMPLETE_IRQ_EN] = command_complete_irq_en;
      end
      OFF_ERROR_STATUS: begin
        next_hrdata[BIT_DOUBLE] = double_fault_flag;
        next_hrdata[BIT_SINGLE] = single_fault_flag;
      end
      OFF_ERROR_CONFIG: begin
        next_hrdata[BIT_DOUBLE] = double_fault_irq_en;
        next_hrdata[BIT_SINGLE] = single_fault_irq_en;
      end
      OFF_PARAM_INDEX: begin
        next_hrdata[2:0] = param_index;
      end
      OFF_COMMAND_PARAM: begin
        if (param_index < 3'(NUM_SLOTS)) begin
          next_hrdata[15:0] = command_param_reg[param_index];
        end
      end
      OFF_PROTECTION: begin
        next_hrdata[16:0] = protection;
      end
      default: begin
        next_hrdata = 32'h00000000; // Unmapped words read as zero.
      end
    endcase
  end

  // Registered read data.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (ap_valid && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  // ********************************************************************
  // Software-owned configuration
  // ********************************************************************

  // Interrupt enables and the protection window.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      command_complete_irq_en <= 1'b0;
      double_fault_irq_en     <= 1'b0;
      single_fault_irq_en     <= 1'b0;
      protection              <= PROTECTION_RST;
    end else begin
      if (wr_hit(dp_write, dp_offset, OFF_FLASH_CONFIG)) begin
        command_complete_irq_en <= hwdata[BIT_COMMAND_COMPLETE_IRQ_EN];
      end
      if (wr_hit(dp_write, dp_offset, OFF_ERROR_CONFIG)) begin
        double_fault_irq_en <= hwdata[BIT_DOUBLE];
        single_fault_irq_en <= hwdata[BIT_SINGLE];
      end
      if (wr_hit(dp_write, dp_offset, OFF_PROTECTION)) begin
        protection <= hwdata[16:0];
      end
    end
  end

  // Index and parameter slots only move while no command runs, so a busy
  // array never sees its words change under it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      param_index <= PARAM_INDEX_RST;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        command_param_reg[i] <= 16'h0000;
      end
    end else if (command_complete_flag) begin
      if (wr_hit(dp_write, dp_offset, OFF_PARAM_INDEX)) begin
        param_index <= hwdata[2:0];
      end
      if (wr_hit(dp_write, dp_offset, OFF_COMMAND_PARAM) &&
          param_index < 3'(NUM_SLOTS)) begin
        command_param_reg[param_index] <= hwdata[15:0];
      end
    end
  end

  // ********************************************************************
  // Launch check
  // ********************************************************************
  dflash_cmd_check #(
    .BLOCK_ID    (BLOCK_ID),
    .DF_SIZE     (DF_SIZE),
    .SECTOR_SIZE (SECTOR_SIZE)
  ) u_check (
    .slot0      (command_param_reg[0]),
    .slot1      (command_param_reg[1]),
    .index      (param_index),
    .mode_ok    (mode_allows_cmd),
    .prot_en    (protection[BIT_PROT_EN]),
    .prot_start (protection[15:0]),
    .access_err (chk_access_err),
    .prot_err   (chk_prot_err),
    .is_erase   (chk_is_erase),
    .word_count (chk_word_count),
    .first_addr (chk_first_addr)
  );

  // A one written to the complete flag while idle is a launch attempt;
  // it goes ahead only when every check passes and no old error stands.
  assign launch_try = wr_hit(dp_write, dp_offset, OFF_FLASH_STATUS) &&
                      hwdata[BIT_CCF] && command_complete_flag;
  assign launch_go  = launch_try && !chk_access_err && !chk_prot_err &&
                      !access_error_flag && !protection_violation_flag &&
                      !hwdata[BIT_ACCESS_ERROR_FLAG] && !hwdata[BIT_PVIOL];

  // ********************************************************************
  // Status flags
  // ********************************************************************

  // Completion and launch errors. A refused launch leaves the complete
  // flag set, so software sees the error without waiting.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      command_complete_flag     <= 1'b1;
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
    end else begin
      if (wr_hit(dp_write, dp_offset, OFF_FLASH_STATUS)) begin
        if (hwdata[BIT_ACCESS_ERROR_FLAG]) begin
          access_error_flag <= 1'b0;
        end
        if (hwdata[BIT_PVIOL]) begin
          protection_violation_flag <= 1'b0;
        end
      end
      if (launch_try && chk_access_err) begin
        access_error_flag <= 1'b1;
      end
      if (launch_try && chk_prot_err) begin
        protection_violation_flag <= 1'b1;
      end
      if (launch_go) begin
        command_complete_flag <= 1'b0;
      end else if (seq_done) begin
        command_complete_flag <= 1'b1;
      end
    end
  end

  // Verify results are cleared at each launch and gathered per operation.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      verify_error_flag <= 1'b0;
      verify_fatal_flag <= 1'b0;
    end else if (launch_go) begin
      verify_error_flag <= 1'b0;
      verify_fatal_flag <= 1'b0;
    end else if (seq_state == SEQ_WAIT && array_done) begin
      if (array_verify_err) begin
        verify_error_flag <= 1'b1;
      end
      if (array_verify_fatal) begin
        verify_fatal_flag <= 1'b1;
      end
    end
  end

  // ECC read faults are sticky; a fault in the clearing cycle survives.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      double_fault_flag <= 1'b0;
      single_fault_flag <= 1'b0;
    end else begin
      if (ecc_double_fault) begin
        double_fault_flag <= 1'b1;
      end else if (wr_hit(dp_write, dp_offset, OFF_ERROR_STATUS) &&
                   hwdata[BIT_DOUBLE]) begin
        double_fault_flag <= 1'b0;
      end
      if (ecc_single_fault) begin
        single_fault_flag <= 1'b1;
      end else if (wr_hit(dp_write, dp_offset, OFF_ERROR_STATUS) &&
                   hwdata[BIT_SINGLE]) begin
        single_fault_flag <= 1'b0;
      end
    end
  end

  // Interrupt requests are plain levels of flag and enable.
  assign irq_cmd_complete = command_complete_flag &&
                            command_complete_irq_en;
  assign irq_double_fault = double_fault_flag &&
                            double_fault_irq_en;
  assign irq_single_fault = single_fault_flag &&
                            single_fault_irq_en;

  // ********************************************************************
  // Array sequencer
  // ********************************************************************

  // One array request per word; an erase is one request for the sector.
  assign seq_done = (seq_state == SEQ_WAIT) && array_done &&
                    (cur_erase || words_left == 3'h1);

  // Walk the words from slot two upward, two bytes apart.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_state  <= SEQ_IDLE;
      words_left <= 3'h0;
      slot_ptr   <= 3'h0;
      cur_erase  <= 1'b0;
      cur_addr   <= 16'h0000;
    end else begin
      case (seq_state)
        SEQ_IDLE: begin
          if (launch_go) begin
            seq_state  <= SEQ_ISSUE;
            words_left <= chk_word_count;
            slot_ptr   <= IDX_PROG_MIN;
            cur_erase  <= chk_is_erase;
            cur_addr   <= chk_first_addr;
          end
        end
        SEQ_ISSUE: begin
          seq_state <= SEQ_WAIT;
        end
        SEQ_WAIT: begin
          if (seq_done) begin
            seq_state <= SEQ_IDLE;
          end else if (array_done) begin
            seq_state  <= SEQ_ISSUE;
            words_left <= words_left - 3'h1;
            slot_ptr   <= slot_ptr + 3'h1;
            cur_addr   <= cur_addr + 16'h0002;
          end
        end
        default: begin
          seq_state <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Array request outputs are registered; array_req pulses for one cycle, the others hold until the next issue.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      array_req   <= 1'b0;
      array_erase <= 1'b0;
      array_addr  <= 16'h0000;
      array_wdata <= 16'h0000;
    end else begin
      array_req <= (seq_state == SEQ_ISSUE);
      if (seq_state == SEQ_ISSUE) begin
        array_erase <= cur_erase;
        array_addr  <= cur_addr;
        array_wdata <= cur_erase ? 16'h0000
                                 : command_param_reg[slot_ptr];
      end
    end
  end

endmodule
`default_nettype wire

// ===== sim/dflash_cmd_sequencer_asserts.sv
// Port assertions for the data-flash command sequencer.
`timescale 1ns/1ns
`default_nettype none
module dflash_seq_checker
  import dflash_seq_pkg::*;
#(
  parameter logic [16:0] DF_SIZE     = DF_SIZE_DEF,
  parameter logic [16:0] SECTOR_SIZE = DF_SECTOR_DEF
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        ecc_single_fault,
  input wire logic        ecc_double_fault,
  input wire logic        array_req,
  input wire logic        array_erase,
  input wire logic [15:0] array_addr,
  input wire logic [15:0] array_wdata,
  input wire logic        array_done,
  input wire logic        irq_cmd_complete,
  input wire logic        irq_double_fault,
  input wire logic        irq_single_fault
);
  // ****************************************************************
  // Helper: a write in its data phase, the only way software moves
  // a flag or an enable, so an interrupt may rise after one.
  // ****************************************************************
  logic wr_dp;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      wr_dp <= 1'b0;
    else if (hready)
      wr_dp <= hsel & htrans[1] & hwrite;
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // An issue is a one-cycle request; the array cannot answer sooner.
  sequence s_issue;
    array_req ##1 !array_req;
  endsequence
  property p_req_gap;
    array_req |-> s_issue ##1 !array_req;
  endproperty
  a_req_gap: assert property (p_req_gap)
    else $error("array requests too close");
  property p_done_gap;
    array_done |=> !array_req;
  endproperty
  a_done_gap: assert property (p_done_gap)
    else $error("request in the cycle after done");
  property p_align;
    array_req |-> !array_addr[0];
  endproperty
  a_align: assert property (p_align)
    else $error("odd array address issued");
  property p_range;
    array_req && !array_erase |-> {1'b0, array_addr} < DF_SIZE;
  endproperty
  a_range: assert property (p_range)
    else $error("word beyond block end issued");
  property p_sector;
    array_req && array_erase |->
      (array_addr & (SECTOR_SIZE[15:0] - 16'h0001)) == 16'h0000;
  endproperty
  a_sector: assert property (p_sector)
    else $error("erase address not a sector base");
  property p_erase_data;
    array_req && array_erase |-> array_wdata == 16'h0000;
  endproperty
  a_erase_data: assert property (p_erase_data)
    else $error("erase carries data");
  property p_irq_cc;
    $rose(irq_cmd_complete) |-> $past(array_done) || $past(wr_dp);
  endproperty
  a_irq_cc: assert property (p_irq_cc)
    else $error("completion interrupt without cause");
  property p_irq_db;
    $rose(irq_double_fault) |-> $past(ecc_double_fault) || $past(wr_dp);
  endproperty
  a_irq_db: assert property (p_irq_db)
    else $error("double fault interrupt without cause");
  property p_irq_sg;
    $rose(irq_single_fault) |-> $past(ecc_single_fault) || $past(wr_dp);
  endproperty
  a_irq_sg: assert property (p_irq_sg)
    else $error("single fault interrupt without cause");
endmodule
`default_nettype wire

// ===== sim/tb_data_flash_cmd_sequencer.sv
// Self-checking testbench of the data-flash command sequencer.
`timescale 1ns/1ns
`default_nettype none
module tb_data_flash_cmd_sequencer
  import dflash_seq_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, mode;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic        array_req, array_erase, array_done, verr, vfatal;
  logic        ecc_single_fault, ecc_double_fault;
  logic        irq_cmd_complete, irq_double_fault, irq_single_fault;
  logic [15:0] array_addr, array_wdata;
  logic [32:0] log_q[$];
  int          failures, n_tests, dly, cnt;

  dflash_cmd_sequencer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .mode_allows_cmd(mode),
    .ecc_single_fault(ecc_single_fault), .ecc_double_fault(ecc_double_fault),
    .array_req(array_req), .array_erase(array_erase),
    .array_addr(array_addr), .array_wdata(array_wdata),
    .array_done(array_done), .array_verify_err(verr),
    .array_verify_fatal(vfatal), .irq_cmd_complete(irq_cmd_complete),
    .irq_double_fault(irq_double_fault), .irq_single_fault(irq_single_fault));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Array stand-in: logs each request, raises done dly+1 cycles after the
  // request cycle, never in the request's own cycle.
  always @(posedge hclk) begin
    array_done <= (array_req !== 1'b1) && (cnt == 1);
    if (array_req === 1'b1) begin
      log_q.push_back({array_erase, array_addr, array_wdata});
      cnt <= dly;
    end else if (cnt > 0)
      cnt <= cnt - 1;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [32:0] e, g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One AHB-Lite single transfer; a hung bus ends the run.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 20);
    q = hrdata;
    if (n >= 20) begin failures++; final_report(); end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, {1'b0, e}, {1'b0, q});
  endtask

  // Slots 0 and 1 take s0 and s1, later slots the words; index ends at last.
  task automatic load(input logic [15:0] s0, s1, input int last);
    for (int i = 0; i <= last; i++) begin
      wr(OFF_PARAM_INDEX, 32'(i));
      wr(OFF_COMMAND_PARAM, i == 0 ? {16'h0, s0} : i == 1 ? {16'h0, s1}
         : 32'(16'h5A00 + i));
    end
  endtask

  task automatic wait_idle;
    logic [31:0] q;
    for (int n = 0; n < 100; n++) begin
      bus(1'b0, OFF_FLASH_STATUS, 32'h0, q);
      if (q[BIT_CCF] === 1'b1) return;
    end
    failures++;
    final_report();
  endtask

  task automatic ecc_pulse(input logic dbl);
    @(posedge hclk);
    ecc_double_fault <= dbl;
    ecc_single_fault <= !dbl;
    @(posedge hclk);
    ecc_double_fault <= 1'b0;
    ecc_single_fault <= 1'b0;
  endtask

  task automatic t_ecc;
    wr(OFF_ERROR_CONFIG, 32'h1);
    ecc_pulse(1'b0);
    rdchk("single flag", OFF_ERROR_STATUS, 32'h1);
    chk("single irq", 1, irq_single_fault);
    wr(OFF_ERROR_STATUS, 32'h1);
    ecc_pulse(1'b1);
    rdchk("double flag", OFF_ERROR_STATUS, 32'h2);
    chk("double masked", 0, irq_double_fault);
    wr(OFF_ERROR_CONFIG, 32'h2);
    rdchk("error config", OFF_ERROR_CONFIG, 32'h2);
    chk("double irq", 1, irq_double_fault);
    wr(OFF_ERROR_STATUS, 32'h2);
    rdchk("flags cleared", OFF_ERROR_STATUS, 32'h0);
    chk("double cleared", 0, irq_double_fault);
    $display("test ecc done");
  endtask

  task automatic t_program;
    int b;
    b = log_q.size();
    wr(OFF_FLASH_CONFIG, 32'h80);
    load(16'h1110, 16'h0100, 5);
    wr(OFF_FLASH_STATUS, 32'h80);
    @(negedge hclk);
    chk("irq busy", 0, irq_cmd_complete);
    wait_idle();
    chk("words", 4, 33'(log_q.size() - b));
    for (int i = 0; i < 4; i++)
      chk("word", {1'b0, 16'(16'h0100 + 2 * i), 16'(16'h5A02 + i)},
          log_q[b + i]);
    chk("irq done", 1, irq_cmd_complete);
    $display("test program done");
  endtask

  // Illegal launches: program index 1 and 6, wrong block, odd address,
  // run past the end, mode refusal, erase index 2, bad code; then protection.
  task automatic t_errors;
    logic [15:0] c0 [8] = '{16'h1110, 16'h1110, 16'h1111, 16'h1110,
                            16'h1110, 16'h1110, 16'h1210, 16'h1310};
    logic [15:0] c1 [8] = '{16'h0100, 16'h0100, 16'h0100, 16'h0101,
                            16'h7FFE, 16'h0100, 16'h0100, 16'h0100};
    int          ln [8] = '{1, 2, 2, 2, 3, 2, 2, 2};
    int          b;
    b = log_q.size();
    for (int k = 0; k < 8; k++) begin
      load(c0[k], c1[k], ln[k]);
      if (k == 1) wr(OFF_PARAM_INDEX, 32'h6);
      mode <= (k != 5);
      wr(OFF_FLASH_STATUS, 32'h80);
      rdchk("access", OFF_FLASH_STATUS, 32'hA0);
      wr(OFF_FLASH_STATUS, 32'h20);
      mode <= 1'b1;
    end
    wr(OFF_PROTECTION, 32'h0001_4000);
    load(16'h1110, 16'h4000, 2);
    wr(OFF_FLASH_STATUS, 32'h80);
    rdchk("protect", OFF_FLASH_STATUS, 32'h90);
    chk("none issued", b, 33'(log_q.size()));
    wr(OFF_FLASH_STATUS, 32'h10);
    wr(OFF_PROTECTION, 32'h0);
    $display("test errors done");
  endtask

  task automatic t_erase;
    int b;
    b = log_q.size();
    verr <= 1'b1;
    vfatal <= 1'b1;
    dly = 30;
    load(16'h1210, 16'h0234, 1);
    wr(OFF_FLASH_STATUS, 32'h80);
    wr(OFF_PARAM_INDEX, 32'h3);
    rdchk("index busy", OFF_PARAM_INDEX, 32'h1);
    wr(OFF_FLASH_STATUS, 32'h80);
    wait_idle();
    chk("erase count", b + 1, 33'(log_q.size()));
    chk("erase op", {1'b1, 16'h0200, 16'h0000}, log_q[b]);
    rdchk("verify", OFF_FLASH_STATUS, 32'h83);
    $display("test erase done");
  endtask

  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, mode, verr, vfatal} = 5'h04;
    {haddr, hwdata, htrans} = '0;
    {ecc_single_fault, ecc_double_fault} = 2'h0;
    {dly, failures, n_tests} = {32'd3, 32'd0, 32'd0};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("status reset", OFF_FLASH_STATUS, 32'h80);
    rdchk("unmapped", 8'h1C, 32'h0);
    chk("hresp", 0, hresp);
    $display("test reset done");
    t_ecc();
    t_program();
    t_errors();
    t_erase();
    final_report();
  end
endmodule

bind dflash_cmd_sequencer dflash_seq_checker #(.DF_SIZE(DF_SIZE),
  .SECTOR_SIZE(SECTOR_SIZE)) chk_u (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .ecc_single_fault(ecc_single_fault), .ecc_double_fault(ecc_double_fault),
  .array_req(array_req), .array_erase(array_erase),
  .array_addr(array_addr), .array_wdata(array_wdata),
  .array_done(array_done), .irq_cmd_complete(irq_cmd_complete),
  .irq_double_fault(irq_double_fault), .irq_single_fault(irq_single_fault));
`default_nettype wire
